// ==== rtrr_pkg.sv ====
// Behaviour
// - Calibrated X sits in bits 31..16 of the screen register, 0x8000 without touch.
// - Calibrated Y sits in bits 15..0 of the screen register, 0x8000 without touch.
// - Calibrated coordinates are clamped inside the configured screen width and height.
// - Resistance samples appear at bits 25..16 and 9..0; other bits read zero.
// - Direct coordinate register carries raw X at 25..16, raw Y at 9..0.
// - Direct coordinate bit 31 is low while a touch is sensed.
// - Direct coordinate bit 31 is high after a sample without touch but reads low after reset; reader ignores both fields.
// - Pressure is computed from raw X and the two resistance samples into the pressure register.
// - Pressure occupies bits 15..0, range 0 to 0x7FFF, upper half reads zero.
// - Pressure 0x7FFF means no touch, 0 means the hardest press.
// - Raw X 0..1023 in bits 31..16 of the raw register, 0xFFFF without touch.
// - Raw Y 0..1023 in bits 15..0 of the raw register, 0xFFFF without touch.
// - Raw register is never calibrated; only the screen register is mapped.
// - A touch counts only when pressure is within the threshold, default 0xFFFF.
package rtrr_pkg;

   localparam int          ADR_W          = 9;
   localparam int          ADC_W          = 10;

   localparam logic [8:0]  OFF_RAW        = 9'h11C;
   localparam logic [8:0]  OFF_PRESS      = 9'h120;
   localparam logic [8:0]  OFF_SCREEN     = 9'h124;
   localparam logic [8:0]  OFF_DIR_XY     = 9'h18C;
   localparam logic [8:0]  OFF_DIR_Z      = 9'h190;
   localparam logic [8:0]  OFF_THRESH     = 9'h118;
   localparam logic [8:0]  OFF_XGAIN      = 9'h1A0;
   localparam logic [8:0]  OFF_XOFS       = 9'h1A4;
   localparam logic [8:0]  OFF_YGAIN      = 9'h1A8;
   localparam logic [8:0]  OFF_YOFS       = 9'h1AC;
   localparam logic [8:0]  OFF_SIZE       = 9'h1B0;
   localparam logic [8:0]  OFF_IRQ_STAT   = 9'h1B4;
   localparam logic [8:0]  OFF_IRQ_MASK   = 9'h1B8;

   localparam logic [31:0] RST_RAW        = 32'hFFFFFFFF;
   localparam logic [31:0] RST_PRESS      = 32'h00007FFF;
   localparam logic [31:0] RST_SCREEN     = 32'h80008000;
   localparam logic [31:0] RST_DIR_XY     = 32'h00000000;
   localparam logic [31:0] RST_DIR_Z      = 32'h00000000;
   localparam logic [15:0] RST_THRESH     = 16'hFFFF;
   localparam logic [31:0] RST_GAIN       = 32'h00010000;
   localparam logic [15:0] RST_OFS        = 16'h0000;
   localparam logic [31:0] RST_SIZE       = 32'h04000400;
   localparam logic [2:0]  RST_IRQ        = 3'h0;

   localparam logic [15:0] RAW_NONE       = 16'hFFFF;
   localparam logic [15:0] SCREEN_NONE    = 16'h8000;
   localparam logic [15:0] PRESS_NONE     = 16'h7FFF;
   localparam int          PRESS_SHIFT    = 5;
   localparam int          DIR_FLAG_BIT   = 31;

   localparam int          EV_SAMPLE      = 0;
   localparam int          EV_PRESS       = 1;
   localparam int          EV_RELEASE     = 2;

   typedef struct packed {
      logic [9:0] x;
      logic [9:0] y;
      logic [9:0] z1;
      logic [9:0] z2;
      logic       contact;
   } rtrr_sample_t;

endpackage : rtrr_pkg

// ==== rtrr_core.sv ====
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module rtrr_core (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [8:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   input  wire rtrr_pkg::rtrr_sample_t sample_i,
   input  wire logic                  sample_valid_i,
   output logic                       touched_o,
   output logic                       irq_o
);

   logic [31:0] raw_reg,    raw_next;
   logic [31:0] press_reg,  press_next;
   logic [31:0] scr_reg,    scr_next;
   logic [31:0] dxy_reg,    dxy_next;
   logic [31:0] dz_reg,     dz_next;
   logic [15:0] thr_reg,    thr_next;
   logic [31:0] xg_reg,     xg_next;
   logic [15:0] xo_reg,     xo_next;
   logic [31:0] yg_reg,     yg_next;
   logic [15:0] yo_reg,     yo_next;
   logic [31:0] size_reg,   size_next;
   logic [2:0]  ist_reg,    ist_next;
   logic [2:0]  imask_reg,  imask_next;
   logic        touch_reg,  touch_next;
   logic        ack_reg,    ack_next;
   logic [31:0] rdat_reg,   rdat_next;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // The sum is kept 27 bits wide so a large gain cannot wrap before the clamp.
   function automatic logic [15:0] cal(input logic [9:0]  raw,
                                       input logic [31:0] gain,
                                       input logic [15:0] ofs,
                                       input logic [15:0] lim);
      logic signed [42:0] prod;
      logic signed [26:0] sum;
      prod = $signed({1'b0, raw}) * $signed(gain);
      sum  = $signed(prod[42:16]) + $signed({{11{ofs[15]}}, ofs});
      if (sum < 0 || lim == 16'h0000) begin
         cal = 16'h0000;
      end else if (sum >= $signed({11'h000, lim})) begin
         cal = lim - 16'h0001;
      end else begin
         cal = sum[15:0];
      end
   endfunction : cal

   // Bus strobes; ack is withheld in the cycle after an answer.
   wire req     = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire wr      = req & wb_we_i;
   wire rd      = req & ~wb_we_i;
   wire [8:0] a = {wb_adr_i[8:2], 2'b00};

   // Pressure rises with the spread between the two samples, so a light touch reads high.
   wire [9:0]  zdiff  = (sample_i.z2 > sample_i.z1) ? (sample_i.z2 - sample_i.z1) : 10'h000;
   wire [19:0] pprod  = sample_i.x * zdiff;
   // The largest product shifted down stays below the no-touch code, so no clamp is needed.
   wire [15:0] pval   = {1'b0, pprod[19:rtrr_pkg::PRESS_SHIFT]};
   wire        accept = sample_i.contact & (sample_i.z1 != 10'h000) & (pval <= thr_reg);

   wire [15:0] cal_x = cal(sample_i.x, xg_reg, xo_reg, size_reg[31:16]);
   wire [15:0] cal_y = cal(sample_i.y, yg_reg, yo_reg, size_reg[15:0]);

   wire [31:0] raw_s = accept ? {6'h00, sample_i.x, 6'h00, sample_i.y}
                              : {rtrr_pkg::RAW_NONE, rtrr_pkg::RAW_NONE};
   wire [31:0] prs_s = accept ? {16'h0000, pval}
                              : {16'h0000, rtrr_pkg::PRESS_NONE};
   wire [31:0] scr_s = accept ? {cal_x, cal_y}
                              : {rtrr_pkg::SCREEN_NONE, rtrr_pkg::SCREEN_NONE};
   wire [31:0] dxy_s = {~accept, 5'h00, sample_i.x, 6'h00, sample_i.y};
   wire [31:0] dz_s  = {6'h00, sample_i.z1, 6'h00, sample_i.z2};

   // One sample strobe loads every result at once.
   assign raw_next   = sample_valid_i ? raw_s : raw_reg;
   assign press_next = sample_valid_i ? prs_s : press_reg;
   assign scr_next   = sample_valid_i ? scr_s : scr_reg;
   assign dxy_next   = sample_valid_i ? dxy_s : dxy_reg;
   assign dz_next    = sample_valid_i ? dz_s  : dz_reg;
   assign touch_next = sample_valid_i ? accept : touch_reg;

   wire [2:0] ev;
   assign ev[rtrr_pkg::EV_SAMPLE]  = sample_valid_i;
   assign ev[rtrr_pkg::EV_PRESS]   = sample_valid_i & accept & ~touch_reg;
   assign ev[rtrr_pkg::EV_RELEASE] = sample_valid_i & ~accept & touch_reg;

   wire wr_thr  = wr & (a == rtrr_pkg::OFF_THRESH);
   wire wr_xg   = wr & (a == rtrr_pkg::OFF_XGAIN);
   wire wr_xo   = wr & (a == rtrr_pkg::OFF_XOFS);
   wire wr_yg   = wr & (a == rtrr_pkg::OFF_YGAIN);
   wire wr_yo   = wr & (a == rtrr_pkg::OFF_YOFS);
   wire wr_size = wr & (a == rtrr_pkg::OFF_SIZE);
   wire wr_mask = wr & (a == rtrr_pkg::OFF_IRQ_MASK);
   wire rd_ist  = rd & (a == rtrr_pkg::OFF_IRQ_STAT);

   wire [31:0] m_thr  = merge({16'h0000, thr_reg}, wb_dat_i, wb_sel_i);
   wire [31:0] m_xo   = merge({16'h0000, xo_reg}, wb_dat_i, wb_sel_i);
   wire [31:0] m_yo   = merge({16'h0000, yo_reg}, wb_dat_i, wb_sel_i);
   wire [31:0] m_mask = merge({29'h0, imask_reg}, wb_dat_i, wb_sel_i);

   assign thr_next   = wr_thr  ? m_thr[15:0] : thr_reg;
   assign xg_next    = wr_xg   ? merge(xg_reg, wb_dat_i, wb_sel_i) : xg_reg;
   assign xo_next    = wr_xo   ? m_xo[15:0] : xo_reg;
   assign yg_next    = wr_yg   ? merge(yg_reg, wb_dat_i, wb_sel_i) : yg_reg;
   assign yo_next    = wr_yo   ? m_yo[15:0] : yo_reg;
   assign size_next  = wr_size ? merge(size_reg, wb_dat_i, wb_sel_i) : size_reg;
   assign imask_next = wr_mask ? m_mask[2:0] : imask_reg;
   // A new event in the reading cycle survives the clear.
   assign ist_next   = (rd_ist ? 3'h0 : ist_reg) | ev;
   assign ack_next   = req;

   always_comb begin
      rdat_next = rdat_reg;
      if (rd) begin
         if (a == rtrr_pkg::OFF_RAW) begin
            rdat_next = raw_reg;
         end else if (a == rtrr_pkg::OFF_PRESS) begin
            rdat_next = press_reg;
         end else if (a == rtrr_pkg::OFF_SCREEN) begin
            rdat_next = scr_reg;
         end else if (a == rtrr_pkg::OFF_DIR_XY) begin
            rdat_next = dxy_reg;
         end else if (a == rtrr_pkg::OFF_DIR_Z) begin
            rdat_next = dz_reg;
         end else if (a == rtrr_pkg::OFF_THRESH) begin
            rdat_next = {16'h0000, thr_reg};
         end else if (a == rtrr_pkg::OFF_XGAIN) begin
            rdat_next = xg_reg;
         end else if (a == rtrr_pkg::OFF_XOFS) begin
            rdat_next = {16'h0000, xo_reg};
         end else if (a == rtrr_pkg::OFF_YGAIN) begin
            rdat_next = yg_reg;
         end else if (a == rtrr_pkg::OFF_YOFS) begin
            rdat_next = {16'h0000, yo_reg};
         end else if (a == rtrr_pkg::OFF_SIZE) begin
            rdat_next = size_reg;
         end else if (a == rtrr_pkg::OFF_IRQ_STAT) begin
            rdat_next = {29'h0, ist_reg};
         end else if (a == rtrr_pkg::OFF_IRQ_MASK) begin
            rdat_next = {29'h0, imask_reg};
         end else begin
            rdat_next = 32'h00000000;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         raw_reg   <= rtrr_pkg::RST_RAW;
         press_reg <= rtrr_pkg::RST_PRESS;
         scr_reg   <= rtrr_pkg::RST_SCREEN;
         dxy_reg   <= rtrr_pkg::RST_DIR_XY;
         dz_reg    <= rtrr_pkg::RST_DIR_Z;
         touch_reg <= 1'b0;
      end else begin
         raw_reg   <= raw_next;
         press_reg <= press_next;
         scr_reg   <= scr_next;
         dxy_reg   <= dxy_next;
         dz_reg    <= dz_next;
         touch_reg <= touch_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         thr_reg   <= rtrr_pkg::RST_THRESH;
         xg_reg    <= rtrr_pkg::RST_GAIN;
         xo_reg    <= rtrr_pkg::RST_OFS;
         yg_reg    <= rtrr_pkg::RST_GAIN;
         yo_reg    <= rtrr_pkg::RST_OFS;
         size_reg  <= rtrr_pkg::RST_SIZE;
      end else begin
         thr_reg   <= thr_next;
         xg_reg    <= xg_next;
         xo_reg    <= xo_next;
         yg_reg    <= yg_next;
         yo_reg    <= yo_next;
         size_reg  <= size_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ist_reg   <= rtrr_pkg::RST_IRQ;
         imask_reg <= rtrr_pkg::RST_IRQ;
         ack_reg   <= 1'b0;
         rdat_reg  <= 32'h00000000;
      end else begin
         ist_reg   <= ist_next;
         imask_reg <= imask_next;
         ack_reg   <= ack_next;
         rdat_reg  <= rdat_next;
      end
   end

   assign wb_ack_o  = ack_reg;
   assign wb_dat_o  = rdat_reg;
   assign touched_o = touch_reg;
   assign irq_o     = |(ist_reg & imask_reg);

endmodule : rtrr_core
`default_nettype wire

// ==== rtrr_panel.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtrr_panel (
   input  wire logic                    clk_i,
   output var rtrr_pkg::rtrr_sample_t   sample_o,
   output var logic                     valid_o
);
   initial begin
      sample_o = '0;
      valid_o  = 1'b0;
   end
   // Idle lines carry the inverse of the last conversion, so stale data never looks fresh.
   task automatic send(input logic [9:0] x, y, z1, z2, input logic c);
      @(posedge clk_i);
      sample_o <= '{x, y, z1, z2, c};
      valid_o  <= 1'b1;
      @(posedge clk_i);
      sample_o <= ~sample_o;
      valid_o  <= 1'b0;
   endtask : send
endmodule : rtrr_panel
`default_nettype wire

// ==== rtrr_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module rtrr_sva (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [8:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        sample_valid_i,
   input wire logic        touched_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic       rd    = wb_ack_o & ~wb_we_i;
   wire logic [6:0] wa    = wb_adr_i[8:2];
   wire logic       r_raw = rd && wa == rtrr_pkg::OFF_RAW[8:2];
   wire logic       r_prs = rd && wa == rtrr_pkg::OFF_PRESS[8:2];
   wire logic       r_scr = rd && wa == rtrr_pkg::OFF_SCREEN[8:2];
   wire logic       r_dxy = rd && wa == rtrr_pkg::OFF_DIR_XY[8:2];
   wire logic       r_dz  = rd && wa == rtrr_pkg::OFF_DIR_Z[8:2];
   sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
   property p_ack; s_take |=> s_ack; endproperty
   a_ack: assert property (p_ack) else $error("ack not a one cycle answer");
   property p_raw_none; r_raw && !$past(touched_o) |-> wb_dat_o == 32'hFFFFFFFF; endproperty
   a_raw_none: assert property (p_raw_none) else $error("raw not marked empty");
   property p_raw_rng; r_raw && $past(touched_o) |-> wb_dat_o[31:26] == 6'h0 && wb_dat_o[15:10] == 6'h0; endproperty
   a_raw_rng: assert property (p_raw_rng) else $error("raw out of range");
   property p_scr_none; r_scr && !$past(touched_o) |-> wb_dat_o == 32'h80008000; endproperty
   a_scr_none: assert property (p_scr_none) else $error("screen not marked empty");
   property p_prs; r_prs |-> wb_dat_o[31:15] == 17'h0; endproperty
   a_prs: assert property (p_prs) else $error("pressure out of range");
   property p_prs_none; r_prs && !$past(touched_o) |-> wb_dat_o[15:0] == 16'h7FFF; endproperty
   a_prs_none: assert property (p_prs_none) else $error("pressure not marked empty");
   property p_dflag; r_dxy && $past(touched_o) |-> !wb_dat_o[31]; endproperty
   a_dflag: assert property (p_dflag) else $error("direct flag set while touched");
   property p_dz; r_dz |-> wb_dat_o[31:26] == 6'h0 && wb_dat_o[15:10] == 6'h0; endproperty
   a_dz: assert property (p_dz) else $error("resistance reserved bits set");
   property p_hold; !sample_valid_i |=> $stable(touched_o); endproperty
   a_hold: assert property (p_hold) else $error("touch state moved without sample");
endmodule : rtrr_sva
bind rtrr_core rtrr_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
   .wb_ack_o, .sample_valid_i, .touched_o);
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic                        clk_i = 1'b0;
   logic                        rst_i = 1'b1;
   logic                        cyc   = 1'b0;
   logic                        we    = 1'b0;
   logic [8:0]                  adr   = 9'h000;
   logic [31:0]                 wd    = 32'h0;
   logic [31:0]                 q;
   wire logic [31:0]            rd;
   wire logic                   ack;
   wire logic                   tch;
   wire logic                   irq;
   wire logic                   sv;
   wire rtrr_pkg::rtrr_sample_t smp;
   int                          fail_count = 0;
   int                          cmp_count  = 0;
   always #20 clk_i = ~clk_i;
   rtrr_panel pnl (.clk_i(clk_i), .sample_o(smp), .valid_o(sv));
   rtrr_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
      .sample_i(smp), .sample_valid_i(sv), .touched_o(tch), .irq_o(irq));
   task automatic chk(input string n, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test
   task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      we  <= w;
      adr <= a;
      wd  <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 9);
      q = rd;
      cyc <= 1'b0;
      we  <= 1'b0;
      if (n >= 9) begin
         fail_count++;
         end_of_test();
      end
   endtask : wb
   task automatic rc(input string n, input logic [8:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(n, q, e);
   endtask : rc
   task automatic rd_all(input logic [31:0] r, p, s, x, z);
      rc("raw", rtrr_pkg::OFF_RAW, r);
      rc("press", rtrr_pkg::OFF_PRESS, p);
      rc("screen", rtrr_pkg::OFF_SCREEN, s);
      rc("dir_xy", rtrr_pkg::OFF_DIR_XY, x);
      rc("dir_z", rtrr_pkg::OFF_DIR_Z, z);
   endtask : rd_all
   task automatic t_reset;
      rd_all(32'hFFFFFFFF, 32'h00007FFF, 32'h80008000, 32'h0, 32'h0);
      wb(1'b1, rtrr_pkg::OFF_RAW, 32'h0);
      rc("ro_raw", rtrr_pkg::OFF_RAW, 32'hFFFFFFFF);
      rc("unmapped", 9'h1FC, 32'h0);
      chk("touched", {31'h0, tch}, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_touch;
      wb(1'b1, rtrr_pkg::OFF_IRQ_MASK, 32'h7);
      pnl.send(10'h064, 10'h0C8, 10'h064, 10'h12C, 1'b1);
      rd_all(32'h006400C8, 32'h00000271, 32'h006400C8, 32'h006400C8, 32'h0064012C);
      chk("touched_on", {31'h0, tch}, 32'h1);
      chk("irq", {31'h0, irq}, 32'h1);
      rc("status", rtrr_pkg::OFF_IRQ_STAT, 32'h3);
      chk("irq_clr", {31'h0, irq}, 32'h0);
      wb(1'b1, rtrr_pkg::OFF_SIZE, 32'h00320032);
      pnl.send(10'h064, 10'h0C8, 10'h064, 10'h12C, 1'b1);
      rc("clamp", rtrr_pkg::OFF_SCREEN, 32'h00310031);
      rc("raw_unmapped", rtrr_pkg::OFF_RAW, 32'h006400C8);
      $display("test touch done");
   endtask : t_touch
   task automatic t_thresh;
      wb(1'b1, rtrr_pkg::OFF_THRESH, 32'h270);
      pnl.send(10'h064, 10'h0C8, 10'h064, 10'h12C, 1'b1);
      rd_all(32'hFFFFFFFF, 32'h00007FFF, 32'h80008000, 32'h806400C8, 32'h0064012C);
      wb(1'b1, rtrr_pkg::OFF_IRQ_MASK, 32'h2);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      rc("status", rtrr_pkg::OFF_IRQ_STAT, 32'h5);
      wb(1'b1, rtrr_pkg::OFF_THRESH, 32'h271);
      pnl.send(10'h064, 10'h0C8, 10'h064, 10'h12C, 1'b1);
      rc("at_thresh", rtrr_pkg::OFF_PRESS, 32'h271);
      pnl.send(10'h005, 10'h005, 10'h12C, 10'h12C, 1'b1);
      rc("hardest", rtrr_pkg::OFF_PRESS, 32'h0);
      pnl.send(10'h005, 10'h005, 10'h12C, 10'h12C, 1'b0);
      rc("no_contact", rtrr_pkg::OFF_DIR_XY, 32'h80050005);
      $display("test threshold done");
   endtask : t_thresh
   task automatic t_cal;
      wb(1'b1, rtrr_pkg::OFF_SIZE, 32'h04000400);
      wb(1'b1, rtrr_pkg::OFF_XGAIN, 32'h00020000);
      wb(1'b1, rtrr_pkg::OFF_XOFS, 32'h0000FFF6);
      wb(1'b1, rtrr_pkg::OFF_YGAIN, 32'h00008000);
      wb(1'b1, rtrr_pkg::OFF_YOFS, 32'h00000005);
      rc("xgain", rtrr_pkg::OFF_XGAIN, 32'h00020000);
      pnl.send(10'h064, 10'h0C8, 10'h064, 10'h12C, 1'b1);
      rc("cal_scaled", rtrr_pkg::OFF_SCREEN, 32'h00BE0069);
      // A negative result after the offset must clamp to zero, not wrap.
      pnl.send(10'h003, 10'h003, 10'h064, 10'h12C, 1'b1);
      rc("cal_floor", rtrr_pkg::OFF_SCREEN, 32'h00000006);
      rc("raw_plain", rtrr_pkg::OFF_RAW, 32'h00030003);
      $display("test calibration done");
   endtask : t_cal
   task automatic t_rerun;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_all(32'hFFFFFFFF, 32'h00007FFF, 32'h80008000, 32'h0, 32'h0);
      rc("thr_rst", rtrr_pkg::OFF_THRESH, 32'h0000FFFF);
      rc("gain_rst", rtrr_pkg::OFF_XGAIN, rtrr_pkg::RST_GAIN);
      rc("stat_rst", rtrr_pkg::OFF_IRQ_STAT, 32'h0);
      chk("touched_rst", {31'h0, tch}, 32'h0);
      $display("test second reset done");
   endtask : t_rerun
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_touch();
      t_thresh();
      t_cal();
      t_rerun();
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
